// File: bench/bdt_branch_ctrl_sva.sv
`timescale 1ns/1ps
`include "bdt_defines.vh"

// Timing relations between branch facts in execute and the fix pulses.
module bdt_branch_ctrl_sva (
    input logic mclk, srst, pipe_adv, if_valid, pred_taken,
    input logic [31:0] if_pc, pred_target, ex_pc, ex_target,
    input logic ex_valid, ex_is_branch, ex_is_imm, ex_is_return,
    input logic ex_is_cond, ex_delay, ex_taken, ex_is_memory_barrier_instr,
    input logic [4:0] ex_memory_barrier_instr_op,
    input logic ex_is_sync_br, ex_exc, irq_req, hw_brk_req,
    input logic [15:0] ex_br_ofs,
    input logic irq_take, hw_brk_take, redirect_q, flush_fetch_q,
    input logic flush_decode_q, flush_prefetch_q, squash_ex_q,
    input logic refill_stall, delay_slot_flag_q, store_clr_q,
    input logic [31:0] redirect_pc_q, branch_target_register_q,
    input logic [31:0] exception_return_addr_reg_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // A delay branch resolving now, and any taken branch resolving now.
    wire dly_br = ex_valid && ex_is_branch && ex_delay;
    wire tkn_br = ex_valid && ex_is_branch && ex_taken;

    flush_fetch_a: assert property (redirect_q |-> flush_fetch_q)
        else $error("redirect without fetch flush");
    slot_keep_a: assert property (
        $past(tkn_br && ex_delay) && redirect_q |-> !flush_decode_q)
        else $error("delay branch flushed decode");
    plain_flush_a: assert property (
        $past(tkn_br && !ex_delay) && redirect_q |-> flush_decode_q
        && flush_prefetch_q && squash_ex_q
        && redirect_pc_q == $past(ex_target))
        else $error("plain taken branch fix wrong");
    slot_cost_a: assert property (
        $rose(refill_stall) && !flush_decode_q |=> !refill_stall)
        else $error("delay slot refill not one cycle");
    taken_cost_a: assert property (
        $rose(refill_stall) && flush_decode_q
        |=> refill_stall ##1 !refill_stall)
        else $error("refill not two cycles");
    irq_hold_a: assert property (
        dly_br || $past(dly_br && pipe_adv) |-> !irq_take && !hw_brk_take)
        else $error("interrupt granted inside delay slot");
    slot_flag_a: assert property (
        $past(tkn_br && ex_delay && pipe_adv) && ex_valid && ex_exc
        |=> delay_slot_flag_q
        && branch_target_register_q == $past(ex_target, 2))
        else $error("slot exception status wrong");
    ret_addr_a: assert property (
        ex_valid && ex_exc && !$past(dly_br && pipe_adv)
        |=> !delay_slot_flag_q
        && exception_return_addr_reg_q == $past(ex_pc) + `BDT_STEP)
        else $error("return address wrong");
    store_clear_a: assert property (
        ex_valid && (ex_is_memory_barrier_instr && ex_memory_barrier_instr_op == `BDT_MEMORY_BARRIER_INSTR_OP
        || ex_is_sync_br && ex_br_ofs == `BDT_SYNC_OFS) |=> store_clr_q)
        else $error("store not cleared");
    clear_miss_a: assert property (store_clr_q |-> !pred_taken)
        else $error("prediction after clear");
endmodule // bdt_branch_ctrl_sva

// File: bench/bdt_branch_ctrl_tb.sv
`timescale 1ns/1ps
`include "bdt_defines.vh"

// Drives branch traffic and checks the fixes through a note queue.
module bdt_branch_ctrl_tb;
    localparam logic [8:0] f_br = 9'h100, f_imm = 9'h080, f_cnd = 9'h020;
    localparam logic [8:0] f_dly = 9'h010, f_tkn = 9'h008, f_exc = 9'h004;
    localparam logic [8:0] f_mb = 9'h002, f_sy = 9'h001;
    localparam logic [8:0] f_ret = 9'h040;
    logic mclk, srst;
    wire pipe_adv, if_valid, ex_valid, ex_exc, irq_req, hw_brk_req;
    wire [31:0] if_pc, ex_pc, ex_target;
    wire ex_is_branch, ex_is_imm, ex_is_return, ex_is_cond;
    wire ex_delay, ex_taken, ex_is_memory_barrier_instr, ex_is_sync_br;
    wire [4:0] ex_memory_barrier_instr_op;
    wire [15:0] ex_br_ofs;
    wire pred_taken, irq_take, hw_brk_take, redirect_q, flush_fetch_q;
    wire flush_decode_q, flush_prefetch_q, squash_ex_q, refill_stall;
    wire delay_slot_flag_q, store_clr_q;
    wire [31:0] pred_target, redirect_pc_q, branch_target_register_q;
    wire [31:0] exception_return_addr_reg_q;
    logic [33:0] notes[$]; // Expected {clear, decode flush, fix address}.
    int miscompares, compares;
    logic [31:0] ta, tb2, td;
    logic [33:0] nt; // Note taken off the queue by the monitor.

    bdt_pipe_model pm (.*);
    bdt_branch_ctrl bdt_branch_ctrl_i (.*);

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // Counts a comparison; four-state equality so unknowns fail.
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic ex(input logic [31:0] a, input logic [8:0] f,
            input logic [31:0] t);
        pm.exec(a, f, t, 5'h1F, 16'hFFFF);
    endtask
    task automatic idle(input int n);
        pm.bubble();
        cyc(n);
    endtask
    function automatic logic [31:0] rnd();
        return ($urandom() & 32'h0FFFFFFC) | 32'h10000000;
    endfunction
    task automatic tally_and_finish();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Each fix or clear pulse takes the oldest note; none left is a fault.
    always @(negedge mclk) begin
        if (!srst && (redirect_q || store_clr_q)) begin
            nt = notes.size() ? notes.pop_front() : 34'h0;
            cmp({store_clr_q, flush_decode_q, redirect_pc_q
                & {32{!store_clr_q}}}, nt);
            cmp({flush_fetch_q, flush_prefetch_q, squash_ex_q},
                {!nt[33], nt[32], nt[32]});
        end
    end

    // A hang ends the run with a counted mismatch.
    initial begin
        #16000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        srst = 1'b1;
        void'($urandom(32'hEA91AAC2));
        {ta, tb2, td} = {rnd(), rnd(), rnd()};
        cyc(20);
        srst = 1'b0;
        notes.push_back({2'h1, ta});
        ex(32'h100, f_br | f_imm | f_tkn, ta);
        idle(1);
        cmp(refill_stall, 34'h1);
        cyc(1);
        cmp(refill_stall, 34'h0);
        cyc(2);
        $display("plain taken branch done");
        {pm.irq_req, pm.hw_brk_req} = 2'h3;
        notes.push_back({2'h0, tb2});
        ex(32'h200, f_br | f_imm | f_dly | f_tkn, tb2);
        cmp({irq_take, hw_brk_take}, 34'h0);
        ex(32'h204, f_exc, rnd());
        cmp({irq_take, hw_brk_take, refill_stall}, 34'h6);
        idle(1);
        cmp({delay_slot_flag_q, branch_target_register_q}, {1'b1, tb2});
        {pm.irq_req, pm.hw_brk_req} = 2'h0;
        idle(3);
        ex(32'h300, f_exc, rnd());
        idle(1);
        cmp({delay_slot_flag_q, exception_return_addr_reg_q},
            {1'b1 ^ 1'b1, 32'h300 + `BDT_STEP});
        $display("delay slot done");
        {pm.if_pc, pm.if_valid} = {32'h100, 1'b1};
        cyc(2);
        cmp({pred_taken, pred_target}, {1'b1, ta});
        ex(32'h100, f_br | f_imm | f_tkn, ta);
        cmp({redirect_q, refill_stall}, 34'h0);
        idle(1);
        $display("correct prediction done");
        notes.push_back({2'h1, td});
        ex(32'h400, f_br | f_imm | f_cnd | f_tkn, td);
        idle(4);
        pm.if_pc = 32'h400;
        cyc(2);
        cmp(pred_taken, 34'h1);
        notes.push_back({2'h1, 32'h400 + `BDT_STEP});
        ex(32'h400, f_br | f_imm | f_cnd, td);
        idle(1);
        cmp(refill_stall, 34'h1);
        cyc(1);
        cmp(refill_stall, 34'h0);
        cyc(2);
        pm.if_pc = 32'h600;
        cyc(2);
        notes.push_back({2'h1, ta});
        ex(32'h600, f_br | f_ret | f_tkn, ta);
        idle(3);
        cmp({pred_taken, pred_target}, {1'b1, ta});
        notes.push_back({2'h1, td});
        ex(32'h600, f_br | f_ret | f_tkn, td);
        idle(4);
        $display("mispredict done");
        for (int k = 0; k < 4; k++) begin
            if (k < 2)
                notes.push_back({2'h2, 32'h0});
            pm.exec(32'h500, k[0] ? f_sy : f_mb, 32'h0, k < 2 ? 5'h00
                : 5'(1 + $urandom_range(30)), k < 2 ? 16'h4 : 16'h8);
            idle(2);
            cmp(pred_taken, 34'h0);
        end
        $display("store clear done");
        cmp(notes.size(), 34'h0);
        tally_and_finish();
    end
endmodule // bdt_branch_ctrl_tb

bind bdt_branch_ctrl bdt_branch_ctrl_sva bdt_branch_ctrl_sva_i (.*);

// File: bench/bdt_pipe_model.sv
`timescale 1ns/1ps

// Behavioural fetch and execute stages feeding the branch controller.
module bdt_pipe_model (
    input logic mclk,
    output logic pipe_adv, if_valid, ex_valid, ex_exc, irq_req, hw_brk_req,
    output logic [31:0] if_pc, ex_pc, ex_target,
    output logic ex_is_branch, ex_is_imm, ex_is_return, ex_is_cond,
    output logic ex_delay, ex_taken, ex_is_memory_barrier_instr, ex_is_sync_br,
    output logic [4:0] ex_memory_barrier_instr_op,
    output logic [15:0] ex_br_ofs
);
    // The pipe always advances; stalls are not modelled here.
    initial begin
        pipe_adv = 1'b1;
        {if_valid, irq_req, hw_brk_req} = 3'h0;
        {if_pc, ex_pc, ex_target} = 96'h0;
        bubble();
    end

    // Puts one instruction in execute for exactly one rising edge.
    // Flag order: branch, imm, return, cond, delay, taken, exc, memory_barrier_instr, sync.
    task automatic exec(input logic [31:0] pc, input logic [8:0] f,
            input logic [31:0] tgt, input logic [4:0] op,
            input logic [15:0] ofs);
        ex_valid = 1'b1;
        ex_pc = pc;
        ex_target = tgt;
        {ex_is_branch, ex_is_imm, ex_is_return, ex_is_cond, ex_delay,
            ex_taken, ex_exc, ex_is_memory_barrier_instr, ex_is_sync_br} = f;
        ex_memory_barrier_instr_op = op;
        ex_br_ofs = ofs;
        @(negedge mclk);
    endtask

    // Empties execute; stale pc and target are inverted so the design cannot
    // lean on values that are no longer qualified.
    task automatic bubble();
        ex_valid = 1'b0;
        ex_pc = ~ex_pc;
        ex_target = ~ex_target;
        {ex_is_branch, ex_is_imm, ex_is_return, ex_is_cond, ex_delay,
            ex_taken, ex_exc, ex_is_memory_barrier_instr, ex_is_sync_br} = 9'h0;
        ex_memory_barrier_instr_op = 5'h1F;
        ex_br_ofs = 16'hFFFF;
    endtask
endmodule // bdt_pipe_model

// File: pkg/bdt_defines.vh
`ifndef BDT_DEFINES_VH
`define BDT_DEFINES_VH

// Pipeline depth selections.
`define BDT_DEPTH_FIVE 2'h0
`define BDT_DEPTH_THREE 2'h1
`define BDT_DEPTH_EIGHT 2'h2

// Target store sizing.
`define BDT_ENTRIES 512
`define BDT_DIST_MAX 64
`define BDT_AW 32

// Entry layout: {uncond, ctr[1:0], target[31:0], tag}.
// These field offsets count from the first bit above the tag.
`define BDT_CTR_LO 32
`define BDT_UNC_BIT 34

// Cycle costs of redirection.
`define BDT_TAKEN_CYC 3'h2
`define BDT_SLOT_CYC 3'h1
`define BDT_MISP5_CYC 3'h2
`define BDT_MISP8_CYC 3'h7

// Store clear operands and instruction step.
`define BDT_MEMORY_BARRIER_INSTR_OP 5'h00
`define BDT_SYNC_OFS 16'h0004
`define BDT_STEP 32'h00000004
`define BDT_STEP2 32'h00000008

`endif

// File: verilog/bdt_branch_ctrl.v
`timescale 1ns/1ps
`include "bdt_defines.vh"

// How it works
// - delay-slot branch flushes fetch only
// - delay slot leaves one refill cycle
// - delayed variant runs next instruction, plain not
// - interrupts wait until branch and slot finish
// - recoverable exceptions allowed in delay slot
// - slot exception sets flag, keeps branch target
// - return address invalid when slot flag set
// - store records targets, hit steers fetch
// - correct prediction costs no stall
// - unconditional taken, conditional uses counter
// - barrier zero or sync branch clears store
// - execute finds three mispredicts, updates store
// - mispredict costs two or seven cycles
// - size parameter, small sizes use distributed
// - block store parity error blocks prediction
// - store exists only in allowed configurations
// - plain taken branch flushes, two cycles
module bdt_branch_ctrl #(
    parameter STORE_EN = 1,
    parameter PIPE_DEPTH = 0,
    parameter FAULT_TOL = 0,
    parameter STORE_SIZE = `BDT_ENTRIES
) (
    input wire mclk,
    input wire srst,
    input wire pipe_adv,
    input wire if_valid,
    input wire [31:0] if_pc,
    output wire pred_taken,
    output wire [31:0] pred_target,
    input wire ex_valid,
    input wire [31:0] ex_pc,
    input wire ex_is_branch,
    input wire ex_is_imm,
    input wire ex_is_return,
    input wire ex_is_cond,
    input wire ex_delay,
    input wire ex_taken,
    input wire [31:0] ex_target,
    input wire ex_is_memory_barrier_instr,
    input wire [4:0] ex_memory_barrier_instr_op,
    input wire ex_is_sync_br,
    input wire [15:0] ex_br_ofs,
    input wire ex_exc,
    input wire irq_req,
    input wire hw_brk_req,
    output wire irq_take,
    output wire hw_brk_take,
    output reg redirect_q,
    output reg [31:0] redirect_pc_q,
    output reg flush_fetch_q,
    output reg flush_decode_q,
    output reg flush_prefetch_q,
    output reg squash_ex_q,
    output wire refill_stall,
    output reg delay_slot_flag_q,
    output reg [31:0] branch_target_register_q,
    output reg [31:0] exception_return_addr_reg_q,
    output reg store_clr_q
);
    // Index and tag widths follow the entry count.
    localparam IDXW = $clog2(STORE_SIZE);
    localparam TW = 30 - IDXW;
    localparam EW = TW + 35;
    // Above the small limit the store goes to block RAM.
    localparam USE_BRAM = (STORE_SIZE > `BDT_DIST_MAX) ? 1 : 0;
    // Parity only makes sense on block RAM.
    localparam PAR_EN = (USE_BRAM == 1 && FAULT_TOL == 1) ? 1 : 0;
    // The three-stage core never carries the store.
    localparam HAS_STORE = (STORE_EN == 1 &&
        (PIPE_DEPTH == 0 || PIPE_DEPTH == 2)) ? 1 : 0;

    // Refill state machine codes.
    localparam S_RUN = 1'b0;
    localparam S_FILL = 1'b1;

    // Index and tag of an instruction address.
    function [IDXW-1:0] idx_of;
        input [31:0] pc;
        begin
            idx_of = pc[IDXW+1:2];
        end
    endfunction

    function [TW-1:0] tag_of;
        input [31:0] pc;
        begin
            tag_of = pc[31:IDXW+2];
        end
    endfunction

    // Store read port results.
    wire rd_valid;
    wire [EW-1:0] rd_entry;
    wire rd_par_ok;
    // Store write port.
    reg wr_en;
    reg [EW-1:0] wr_entry;
    // Store clear from execute.
    wire clr_now;

    // Prediction carried beside the instruction through decode, execute.
    reg de_pt_q;
    reg [31:0] de_ptgt_q;
    reg [1:0] de_ctr_q;
    reg de_hit_q;
    reg ex_pt_q;
    reg [31:0] ex_ptgt_q;
    reg [1:0] ex_ctr_q;
    reg ex_hit_q;

    // Delay-slot tracking: the slot sits in execute after its branch.
    reg slot_in_ex_q;
    reg [31:0] slot_tgt_q;

    // Refill counter and state.
    reg state_q;
    reg [2:0] bub_q;
    reg [2:0] cost;

    // Lookup in fetch.
    wire hit;
    wire [1:0] hit_ctr;
    wire if_pt;

    generate
        if (HAS_STORE == 1) begin : g_store
            bdt_target_store #(
                .ENTRIES(STORE_SIZE),
                .IDXW(IDXW),
                .EW(EW),
                .PAR_EN(PAR_EN)
            ) u_store (
                .mclk(mclk),
                .srst(srst),
                .clr(clr_now),
                .rd_idx(idx_of(if_pc)),
                .rd_valid(rd_valid),
                .rd_entry(rd_entry),
                .rd_par_ok(rd_par_ok),
                .wr_en(wr_en),
                .wr_idx(idx_of(ex_pc)),
                .wr_entry(wr_entry)
            );
        end else begin : g_none
            // Without a store nothing is ever predicted.
            assign rd_valid = 1'b0;
            assign rd_entry = {EW{1'b0}};
            assign rd_par_ok = 1'b0;
        end
    endgenerate

    // A bad parity entry is treated as a miss.
    assign hit = if_valid && rd_valid && rd_par_ok &&
        (rd_entry[TW-1:0] == tag_of(if_pc));
    // Counter and kind sit above the tag, so offset by the tag width.
    assign hit_ctr = rd_entry[TW+`BDT_CTR_LO+1:TW+`BDT_CTR_LO];
    // Unconditional entries always go, others follow the counter.
    assign if_pt = hit && (rd_entry[TW+`BDT_UNC_BIT] || hit_ctr[1]);
    // Combinational so fetch turns in the same cycle.
    assign pred_taken = if_pt;
    assign pred_target = rd_entry[31+TW:TW];

    // Barrier zero or sync branch by four empties the store.
    assign clr_now = ex_valid && ((ex_is_memory_barrier_instr &&
        ex_memory_barrier_instr_op == `BDT_MEMORY_BARRIER_INSTR_OP) || (ex_is_sync_br &&
        ex_br_ofs == `BDT_SYNC_OFS));

    // Carry the prediction alongside its instruction.
    always @(posedge mclk) begin
        if (srst) begin
            de_pt_q <= 1'b0;
            de_ptgt_q <= 32'h00000000;
            de_ctr_q <= 2'h0;
            de_hit_q <= 1'b0;
            ex_pt_q <= 1'b0;
            ex_ptgt_q <= 32'h00000000;
            ex_ctr_q <= 2'h0;
            ex_hit_q <= 1'b0;
        end else if (pipe_adv) begin
            de_pt_q <= if_pt;
            de_ptgt_q <= pred_target;
            de_ctr_q <= hit_ctr;
            de_hit_q <= hit;
            ex_pt_q <= de_pt_q;
            ex_ptgt_q <= de_ptgt_q;
            ex_ctr_q <= de_ctr_q;
            ex_hit_q <= de_hit_q;
        end
    end

    // Resolution terms in execute.
    wire resolve = ex_valid && ex_is_branch;
    // A store-backed kind is an immediate branch or a return.
    wire tracked = ex_is_imm || ex_is_return;
    // Three mispredict cases: wrong taken, wrong not taken, bad target.
    wire mis_t = ex_pt_q && !ex_taken;
    wire mis_nt = !ex_pt_q && ex_taken;
    wire mis_tgt = ex_pt_q && ex_taken && (ex_ptgt_q != ex_target);
    wire mispred = resolve && ex_hit_q &&
        (mis_t || mis_nt || mis_tgt);
    // Taken with no valid prediction is a normal taken branch.
    wire plain_tk = resolve && !ex_hit_q && ex_taken;
    wire need_fix = mispred || plain_tk;
    // Where to resume: the target, or the next in line past any slot.
    wire [31:0] fall_pc = ex_delay ? (ex_pc + `BDT_STEP2) :
        (ex_pc + `BDT_STEP);
    wire [31:0] fix_pc = ex_taken ? ex_target : fall_pc;

    // Saturating two-bit counter update.
    reg [1:0] ctr_new;
    always @* begin
        ctr_new = ex_hit_q ? ex_ctr_q : (ex_taken ? 2'h2 : 2'h1);
        if (ex_hit_q && ex_taken && ex_ctr_q != 2'h3) begin
            ctr_new = ex_ctr_q + 2'h1;
        end else if (ex_hit_q && !ex_taken && ex_ctr_q != 2'h0) begin
            ctr_new = ex_ctr_q - 2'h1;
        end
    end

    // Record every immediate branch and return in execute.
    always @* begin
        wr_en = resolve && tracked && (HAS_STORE == 1);
        wr_entry = {(!ex_is_cond), ctr_new, ex_target, tag_of(ex_pc)};
    end

    // Cycle cost of the correction in hand.
    always @* begin
        if (mispred) begin
            cost = (PIPE_DEPTH == 2) ? `BDT_MISP8_CYC :
                `BDT_MISP5_CYC;
        end else if (ex_delay) begin
            cost = `BDT_SLOT_CYC;
        end else begin
            cost = `BDT_TAKEN_CYC;
        end
    end

    // Redirect and flush pulses, one cycle after execute decides.
    always @(posedge mclk) begin
        if (srst) begin
            redirect_q <= 1'b0;
            redirect_pc_q <= 32'h00000000;
            flush_fetch_q <= 1'b0;
            flush_decode_q <= 1'b0;
            flush_prefetch_q <= 1'b0;
            squash_ex_q <= 1'b0;
            store_clr_q <= 1'b0;
        end else begin
            redirect_q <= need_fix;
            store_clr_q <= clr_now;
            if (need_fix) begin
                redirect_pc_q <= fix_pc;
            end
            // Fetch is always wrong-path after a fix.
            flush_fetch_q <= need_fix;
            // A slot in decode survives; otherwise decode dies too.
            flush_decode_q <= need_fix && !ex_delay;
            flush_prefetch_q <= need_fix && !ex_delay;
            // Wrong-path work is killed before it writes anything.
            squash_ex_q <= need_fix && !ex_delay;
        end
    end

    // Refill bubbles: zero when the prediction was right.
    always @(posedge mclk) begin
        if (srst) begin
            state_q <= S_RUN;
            bub_q <= 3'h0;
        end else begin
            case (state_q)
                S_RUN: begin
                    if (need_fix) begin
                        state_q <= S_FILL;
                        bub_q <= cost;
                    end
                end
                S_FILL: begin
                    if (bub_q == 3'h1) begin
                        state_q <= S_RUN;
                    end
                    bub_q <= bub_q - 3'h1;
                end
                default: begin
                    state_q <= S_RUN;
                    bub_q <= 3'h0;
                end
            endcase
        end
    end

    assign refill_stall = (state_q == S_FILL);

    // Track the slot instruction as it follows its branch into execute.
    // The slot is assumed free of prefixes, branches and breaks.
    always @(posedge mclk) begin
        if (srst) begin
            slot_in_ex_q <= 1'b0;
            slot_tgt_q <= 32'h00000000;
        end else if (pipe_adv) begin
            slot_in_ex_q <= resolve && ex_delay;
            if (resolve && ex_delay) begin
                slot_tgt_q <= fix_pc;
            end
        end
    end

    // Interrupts and hardware breaks wait out the branch and its slot.
    wire hold = (resolve && ex_delay) || slot_in_ex_q;
    assign irq_take = irq_req && !hold;
    assign hw_brk_take = hw_brk_req && !hold;

    // Exception status capture. Faults in a slot are still taken.
    always @(posedge mclk) begin
        if (srst) begin
            delay_slot_flag_q <= 1'b0;
            branch_target_register_q <= 32'h00000000;
            exception_return_addr_reg_q <= 32'h00000000;
        end else if (ex_valid && ex_exc) begin
            if (slot_in_ex_q) begin
                // Handler resumes at the branch destination.
                delay_slot_flag_q <= 1'b1;
                branch_target_register_q <= slot_tgt_q;
            end else begin
                delay_slot_flag_q <= 1'b0;
                exception_return_addr_reg_q <= ex_pc + `BDT_STEP;
            end
        end
    end
endmodule // bdt_branch_ctrl

// File: verilog/bdt_target_store.v
`timescale 1ns/1ps
`include "bdt_defines.vh"

// Entry array of the branch target store with optional parity.
module bdt_target_store #(
    parameter ENTRIES = `BDT_ENTRIES,
    parameter IDXW = 9,
    parameter EW = 56,
    parameter PAR_EN = 0
) (
    input wire mclk,
    input wire srst,
    input wire clr,
    input wire [IDXW-1:0] rd_idx,
    output wire rd_valid,
    output wire [EW-1:0] rd_entry,
    output wire rd_par_ok,
    input wire wr_en,
    input wire [IDXW-1:0] wr_idx,
    input wire [EW-1:0] wr_entry
);
    // Entry storage and one parity bit per entry.
    reg [EW-1:0] mem [0:ENTRIES-1];
    reg par_mem [0:ENTRIES-1];
    // Valid bits sit in flops so that a clear takes one cycle.
    reg [ENTRIES-1:0] vld_q;

    // Writes store the entry and its even parity.
    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_entry;
            par_mem[wr_idx] <= ^wr_entry;
        end
    end

    // A clear beats a write in the same cycle.
    always @(posedge mclk) begin
        if (srst || clr) begin
            vld_q <= {ENTRIES{1'b0}};
        end else if (wr_en) begin
            vld_q[wr_idx] <= 1'b1;
        end
    end

    // Reads are combinational so a hit steers fetch with no stall.
    assign rd_entry = mem[rd_idx];
    assign rd_valid = vld_q[rd_idx];
    // Without parity every read is trusted.
    assign rd_par_ok = (PAR_EN == 0) || (par_mem[rd_idx] == ^mem[rd_idx]);
endmodule // bdt_target_store
